// file: core/mmu_pkg.sv
// Shared constants, field layouts and carrier types of the translation unit
package mmu_pkg;
  // Address widths and table geometry
  localparam int unsigned PA_W = 29;
  localparam int unsigned TAG_W = 8;
  localparam int unsigned WAYS = 4;
  localparam int unsigned SETS = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned WAY_W = 2;
  // Register addresses as printed; only the low byte is decoded in control space
  localparam logic [31:0] OFF_TABLE_BASE = 32'h0ffffff8;
  localparam logic [31:0] OFF_XLAT_CTRL = 32'hffffffe0;
  localparam logic [31:0] OFF_PTE_HIGH = 32'hfffffff0;
  localparam logic [31:0] OFF_PTE_LOW = 32'hfffffff4;
  localparam logic [31:0] OFF_FAULT_ADDR = 32'hfffffffc;
  // Control register fields
  localparam int unsigned CTL_XLAT_BIT = 0;
  localparam int unsigned CTL_FLUSH_BIT = 2;
  localparam int unsigned CTL_WAY_LSB = 6;
  localparam int unsigned CTL_SINGLE_BIT = 8;
  // Virtual address fields
  localparam int unsigned VA_TOP_LSB = 29;
  localparam int unsigned VA_HI_LSB = 17;
  localparam int unsigned VA_IDX_LSB = 12;
  localparam int unsigned VA_LO_LSB = 10;
  localparam int unsigned PG4K_LSB = 12;
  localparam int unsigned PG1K_LSB = 10;
  localparam int unsigned XY_LSB = 24;
  // Region codes in the top three address bits
  localparam logic [2:0] TOP_FIXED_C = 3'h4;
  localparam logic [2:0] TOP_FIXED_C2 = 3'h5;
  localparam logic [2:0] TOP_FIXED_U = 3'h5;
  localparam logic [2:0] TOP_HIGH = 3'h6;
  localparam logic [2:0] TOP_CTRL = 3'h7;
  // Top byte of the user-mode DSP window
  localparam logic [7:0] XY_TOP = 8'ha5;
  // Page entry low layout
  localparam int unsigned PPN_LSB = 10;
  localparam int unsigned V_BIT = 8;
  localparam int unsigned PR_LSB = 5;
  localparam int unsigned SZ_BIT = 4;
  localparam int unsigned C_BIT = 3;
  localparam int unsigned D_BIT = 2;
  localparam int unsigned SH_BIT = 1;
  localparam logic [31:0] CTL_RST = 32'h0;

  // Decoded virtual region
  typedef enum logic [2:0] {
    RGN_LOW_MAPPED, RGN_USER_MAPPED, RGN_FIXED_CACHED, RGN_FIXED_UNCACHED,
    RGN_HIGH_MAPPED, RGN_CONTROL, RGN_DSP_XY, RGN_BAD
  } region_e;

  // One translation entry
  typedef struct packed {
    logic [14:0] vpn_hi;
    logic [1:0] vpn_lo;
    logic [TAG_W-1:0] tag;
    logic shared;
    logic big_page;
    logic valid;
    logic [18:0] ppn;
    logic [1:0] rights;
    logic cacheable;
    logic dirty;
  } tlb_entry_s;

  // Access offered by the core
  typedef struct packed {
    logic [31:0] vaddr;
    logic write;
    logic priv;
    logic [31:0] wdata;
  } cpu_access_s;

  // Translation answer
  typedef struct packed {
    logic [PA_W-1:0] paddr;
    logic cacheable;
    logic writethrough;
    logic ctrl_space;
    logic xy_space;
    logic miss;
    logic prot;
    logic addr_err;
  } xlat_res_s;
endpackage

// file: core/tlb_way.sv
// One way of the translation buffer: 32 entries with resettable valid bits
module tlb_way
  import mmu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire logic wr_en_i,
  input wire logic [IDX_W-1:0] wr_idx_i,
  input wire tlb_entry_s wr_data_i,
  input wire logic [IDX_W-1:0] rd_idx_i,
  output tlb_entry_s rd_data_o
);
  // Entry payload, left unreset on purpose
  tlb_entry_s mem_r [SETS];
  // Valid bits, cleared by reset and flush
  logic [SETS-1:0] valid_r;

  // Payload store
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_r[wr_idx_i] <= wr_data_i;
    end
  end

  // Valid bit per entry
  for (genvar g = 0; g < SETS; g++)
  begin : g_valid
    always_ff @(posedge ref_clk_i)
    begin
      if (sys_rst_i || flush_i)
      begin
        valid_r[g] <= 1'b0;
      end
      else if (wr_en_i && wr_idx_i == IDX_W'(g))
      begin
        valid_r[g] <= wr_data_i.valid;
      end
    end
  end

  // Read port with the live valid bit merged in
  always_comb
  begin
    rd_data_o = mem_r[rd_idx_i];
    rd_data_o.valid = valid_r[rd_idx_i];
  end
endmodule // tlb_way

// file: core/mmu_translate.sv
// Virtual address translation unit with region decode and four-way buffer
// Overview of operation
// RL1 - Pages of 1 or 4 Kbytes only
// RL2 - Mapped regions cache when enabled and page cacheable
// RL3 - Fixed cached region maps low, caches if enabled
// RL4 - Fixed uncached and control space never cache
// RL5 - DSP window uncached, usable only when enabled
// RL6 - Fixed regions bypass the buffer entirely
// RL7 - Mapped regions search buffer, hit supplies page
// RL8 - No match raises miss; core retries later
// RL9 - Software avoids mapping into high physical range
// RL10 - Translation off passes low 29 bits through
// RL11 - Cache address has top three bits zeroed
// RL12 - Single/multiple mode changes the compare and user protection
// RL13 - Eight-bit process tag held in entry high
// RL14 - Tag change alone switches process, no purge
// RL15 - Single mode uses tag for protection
// RL16 - Page rights separate privileged from user
// RL17 - Reset clears control bits except single select
// RL18 - Software uncaches pages mapping peripheral area
// RL19 - Buffer is four ways of 32 entries
// RL20 - Fault address captured on fault, held
// RL21 - Entry high page number loaded on fault
// RL22 - Only valid entries can hit
// RL23 - Registers reachable only privileged in control space
module mmu_translate
  import mmu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic acc_valid_i,
  input wire cpu_access_s access_i,
  input wire logic tlb_load_i,
  input wire logic cache_on_i,
  input wire logic mapped_writethrough_sel_i,
  input wire logic fixed_copyback_sel_i,
  input wire logic dsp_extension_on_i,
  output logic resp_valid_o,
  output xlat_res_s result_o,
  output logic [31:0] cache_addr_o,
  output logic [31:0] rdata_o
);
  // Software visible state
  logic xlat_on_r;
  logic single_space_sel_r;
  logic [WAY_W-1:0] load_way_r;
  logic [31:0] page_entry_high_r;
  logic [31:0] page_entry_low_r;
  logic [31:0] table_base_r;
  logic [31:0] fault_address_r;
  // Buffer plumbing
  tlb_entry_s way_rd [WAYS];
  tlb_entry_s load_entry;
  logic [WAYS-1:0] way_we;
  logic flush;
  // Decode and answer of the current access
  region_e region;
  xlat_res_s res_nxt;
  logic [31:0] rdata_nxt;
  logic reg_hit;
  logic wr_ctrl;
  logic wr_high;
  logic wr_low;
  logic wr_base;
  logic wr_fault;
  logic fault;
  cpu_access_s acc;
  // Snapshot kept only for checking
  logic [31:0] va_r;
  logic priv_r;
  logic xlat_r;
  region_e region_r;

  assign acc = access_i;

  // Region decode; user mode sees only the low half and the DSP window
  function automatic region_e region_of(input logic [31:0] va, input logic priv,
                                        input logic dsp_on);
    region_e r;
    r = RGN_BAD;
    if (!priv)
    begin
      if (!va[31])
        r = RGN_USER_MAPPED;
      // RL5 DSP window gate
      else if (va[31:XY_LSB] == XY_TOP && dsp_on)
        r = RGN_DSP_XY;
    end
    else
    begin
      case (va[31:VA_TOP_LSB])
        TOP_FIXED_C: r = RGN_FIXED_CACHED;
        TOP_FIXED_U: r = RGN_FIXED_UNCACHED;
        TOP_HIGH: r = RGN_HIGH_MAPPED;
        TOP_CTRL: r = RGN_CONTROL;
        default: r = RGN_LOW_MAPPED;
      endcase
    end
    return r;
  endfunction

  // RL12 mode alters this comparison and the RL15 user protection check
  // RL22 invalid entries never match
  function automatic logic entry_match(input tlb_entry_s e, input logic [31:0] va,
                                       input logic [TAG_W-1:0] tag, input logic single);
    logic lo_ok;
    logic tag_ok;
    // RL1 large pages ignore the two small-page bits
    lo_ok = e.big_page || e.vpn_lo == va[VA_IDX_LSB-1:VA_LO_LSB];
    // RL14 tag keeps processes apart without purging
    tag_ok = single || e.shared || e.tag == tag;
    return e.valid && e.vpn_hi == va[31:VA_HI_LSB] && lo_ok && tag_ok;
  endfunction

  // RL16 rights: bit 1 opens user access, bit 0 opens writes
  function automatic logic rights_ok(input logic [1:0] pr, input logic priv,
                                     input logic write);
    return (priv || pr[1]) && (!write || pr[0]);
  endfunction

  // Register decode is used for both read and write paths
  function automatic logic reg_sel(input logic [31:0] va, input logic [31:0] off);
    return va[7:0] == off[7:0];
  endfunction

  // RL19 four ways share one index taken from the address
  for (genvar w = 0; w < WAYS; w++)
  begin : g_way
    tlb_way u_way (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .flush_i(flush),
      .wr_en_i(way_we[w]),
      .wr_idx_i(page_entry_high_r[VA_HI_LSB-1:VA_IDX_LSB]),
      .wr_data_i(load_entry),
      .rd_idx_i(acc.vaddr[VA_HI_LSB-1:VA_IDX_LSB]),
      .rd_data_o(way_rd[w])
    );
    assign way_we[w] = tlb_load_i && load_way_r == WAY_W'(w);
  end

  // Entry built from the staging registers when the core loads the buffer
  always_comb
  begin
    load_entry.vpn_hi = page_entry_high_r[31:VA_HI_LSB];
    load_entry.vpn_lo = page_entry_high_r[VA_IDX_LSB-1:VA_LO_LSB];
    // RL13 process tag sits in the low byte
    load_entry.tag = page_entry_high_r[TAG_W-1:0];
    load_entry.shared = page_entry_low_r[SH_BIT];
    load_entry.big_page = page_entry_low_r[SZ_BIT];
    load_entry.valid = page_entry_low_r[V_BIT];
    load_entry.ppn = page_entry_low_r[PA_W-1:PPN_LSB];
    load_entry.rights = page_entry_low_r[PR_LSB+1:PR_LSB];
    load_entry.cacheable = page_entry_low_r[C_BIT];
    load_entry.dirty = page_entry_low_r[D_BIT];
  end

  // Register strobes; anything else in control space is a plain pass-through
  always_comb
  begin
    region = region_of(acc.vaddr, acc.priv, dsp_extension_on_i);
    // RL23 only privileged control-space accesses reach registers
    reg_hit = acc_valid_i && region == RGN_CONTROL && acc.priv;
    wr_ctrl = reg_hit && acc.write && reg_sel(acc.vaddr, OFF_XLAT_CTRL);
    wr_high = reg_hit && acc.write && reg_sel(acc.vaddr, OFF_PTE_HIGH);
    wr_low = reg_hit && acc.write && reg_sel(acc.vaddr, OFF_PTE_LOW);
    wr_base = reg_hit && acc.write && reg_sel(acc.vaddr, OFF_TABLE_BASE);
    wr_fault = reg_hit && acc.write && reg_sel(acc.vaddr, OFF_FAULT_ADDR);
    flush = wr_ctrl && acc.wdata[CTL_FLUSH_BIT];
  end

  // Read data; the flush bit always reads zero
  always_comb
  begin
    rdata_nxt = '0;
    if (reg_hit && !acc.write)
    begin
      if (reg_sel(acc.vaddr, OFF_XLAT_CTRL))
      begin
        rdata_nxt[CTL_XLAT_BIT] = xlat_on_r;
        rdata_nxt[CTL_WAY_LSB+WAY_W-1:CTL_WAY_LSB] = load_way_r;
        rdata_nxt[CTL_SINGLE_BIT] = single_space_sel_r;
      end
      else if (reg_sel(acc.vaddr, OFF_PTE_HIGH))
        rdata_nxt = page_entry_high_r;
      else if (reg_sel(acc.vaddr, OFF_PTE_LOW))
        rdata_nxt = page_entry_low_r;
      else if (reg_sel(acc.vaddr, OFF_TABLE_BASE))
        rdata_nxt = table_base_r;
      else if (reg_sel(acc.vaddr, OFF_FAULT_ADDR))
        rdata_nxt = fault_address_r;
    end
  end

  // Translation of the current access
  always_comb
  begin
    logic hit;
    logic tag_same;
    tlb_entry_s e;
    hit = 1'b0;
    e = way_rd[0];
    tag_same = 1'b0;
    res_nxt = '0;
    // RL10 default is a pass-through of the low 29 bits
    res_nxt.paddr = acc.vaddr[PA_W-1:0];
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      if (entry_match(way_rd[w], acc.vaddr, page_entry_high_r[TAG_W-1:0],
                      single_space_sel_r))
      begin
        hit = 1'b1;
        e = way_rd[w];
      end
    end
    tag_same = e.shared || e.tag == page_entry_high_r[TAG_W-1:0];
    case (region)
      RGN_LOW_MAPPED, RGN_USER_MAPPED, RGN_HIGH_MAPPED:
      begin
        res_nxt.writethrough = mapped_writethrough_sel_i;
        if (!xlat_on_r)
          res_nxt.cacheable = cache_on_i;
        // RL7 buffer search on mapped regions
        else if (hit)
        begin
          // RL1 4K pages keep 12 offset bits, 1K pages keep 10
          if (e.big_page)
            res_nxt.paddr = {e.ppn[18:2], acc.vaddr[PG4K_LSB-1:0]};
          else
            res_nxt.paddr = {e.ppn, acc.vaddr[PG1K_LSB-1:0]};
          // RL2 caching needs both enables
          res_nxt.cacheable = cache_on_i && e.cacheable;
          // RL16 page rights
          // RL15 single mode blocks user access to another tag
          res_nxt.prot = !rights_ok(e.rights, acc.priv, acc.write)
                         || (single_space_sel_r && !acc.priv && !tag_same);
        end
        // RL8 miss is reported, the core re-executes after refill
        else
          res_nxt.miss = 1'b1;
      end
      // RL3 fixed cached region
      // RL6 no buffer lookup here
      RGN_FIXED_CACHED:
      begin
        res_nxt.cacheable = cache_on_i;
        res_nxt.writethrough = !fixed_copyback_sel_i;
      end
      // RL4 never cached
      RGN_FIXED_UNCACHED: res_nxt.cacheable = 1'b0;
      RGN_CONTROL: res_nxt.ctrl_space = 1'b1;
      RGN_DSP_XY: res_nxt.xy_space = 1'b1;
      default: res_nxt.addr_err = 1'b1;
    endcase
    if (res_nxt.miss || res_nxt.prot || res_nxt.addr_err)
    begin
      res_nxt.cacheable = 1'b0;
    end
  end

  assign fault = acc_valid_i && (res_nxt.miss || res_nxt.prot || res_nxt.addr_err);

  // Control register; single select is left as it was across reset
  // RL17 reset clears the other control bits
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      xlat_on_r <= CTL_RST[CTL_XLAT_BIT];
      load_way_r <= CTL_RST[CTL_WAY_LSB+WAY_W-1:CTL_WAY_LSB];
    end
    else if (wr_ctrl)
    begin
      xlat_on_r <= acc.wdata[CTL_XLAT_BIT];
      load_way_r <= acc.wdata[CTL_WAY_LSB+WAY_W-1:CTL_WAY_LSB];
    end
    else if (tlb_load_i)
    begin
      // Round-robin victim choice, software may override it
      load_way_r <= load_way_r + WAY_W'(1);
    end
  end

  // Unreset mode bit
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_ctrl)
    begin
      single_space_sel_r <= acc.wdata[CTL_SINGLE_BIT];
    end
  end

  // Staging registers; a fault wins over nothing since both come from one access
  always_ff @(posedge ref_clk_i)
  begin
    if (fault)
    begin
      // RL21 page number of the faulting address
      page_entry_high_r[31:VA_LO_LSB] <= acc.vaddr[31:VA_LO_LSB];
    end
    else if (wr_high)
    begin
      page_entry_high_r <= acc.wdata;
    end
    if (wr_low)
    begin
      page_entry_low_r <= acc.wdata;
    end
    if (wr_base)
    begin
      table_base_r <= acc.wdata;
    end
  end

  // RL20 fault address held until the next fault or a register write
  always_ff @(posedge ref_clk_i)
  begin
    if (fault)
    begin
      fault_address_r <= acc.vaddr;
    end
    else if (wr_fault)
    begin
      fault_address_r <= acc.wdata;
    end
  end

  // Registered answer; one cycle after each offered access
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      resp_valid_o <= 1'b0;
      result_o <= '0;
      cache_addr_o <= '0;
      rdata_o <= '0;
    end
    else
    begin
      resp_valid_o <= acc_valid_i;
      result_o <= acc_valid_i ? res_nxt : '0;
      // RL11 cache array address loses the top three bits
      cache_addr_o <= {3'h0, res_nxt.paddr};
      rdata_o <= rdata_nxt;
    end
  end

  // Snapshot for the checks below
  always_ff @(posedge ref_clk_i)
  begin
    va_r <= acc.vaddr;
    priv_r <= acc.priv;
    xlat_r <= xlat_on_r;
    region_r <= region;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rst_release;
    sys_rst_i ##1 !sys_rst_i;
  endsequence

  sequence s_fault_seen;
    resp_valid_o && (result_o.miss || result_o.prot || result_o.addr_err);
  endsequence

  fault_addr_hold_a: assert property (s_fault_seen |-> fault_address_r == va_r // RL20
    && page_entry_high_r[31:VA_LO_LSB] == va_r[31:VA_LO_LSB])
    else $error("fault address not captured");
  fixed_no_miss_a: assert property (resp_valid_o && (region_r == RGN_FIXED_CACHED // RL6
    || region_r == RGN_FIXED_UNCACHED) |-> !result_o.miss
    && result_o.paddr == va_r[PA_W-1:0])
    else $error("fixed region used buffer");
  pass_through_a: assert property (resp_valid_o && !xlat_r // RL10
    |-> result_o.paddr == va_r[PA_W-1:0] && !result_o.miss)
    else $error("untranslated address altered");
  // Untranslated aliases must land on one cache address, not merely copy paddr
  cache_tag_a: assert property (resp_valid_o |-> cache_addr_o == {3'h0, result_o.paddr} // RL11
    && (xlat_r || cache_addr_o[PA_W-1:0] == va_r[PA_W-1:0]))
    else $error("cache address top bits not cleared");
  uncached_area_a: assert property (resp_valid_o && (result_o.ctrl_space // RL4
    || result_o.xy_space || region_r == RGN_FIXED_UNCACHED) |-> !result_o.cacheable)
    else $error("uncached region cached");
  dsp_gate_a: assert property (result_o.xy_space |-> $past(dsp_extension_on_i)) // RL5
    else $error("DSP window used while disabled");
  reset_ctrl_a: assert property (disable iff (1'b0) s_rst_release // RL17
    |-> !xlat_on_r && load_way_r == '0)
    else $error("control bits not cleared by reset");
  user_high_a: assert property (resp_valid_o && !priv_r && va_r[31] // RL16
    && !result_o.xy_space |-> result_o.addr_err)
    else $error("user access to privileged area allowed");
  fixed_cache_a: assert property (acc_valid_i && acc.priv // RL3
    && acc.vaddr[31:VA_TOP_LSB] == TOP_FIXED_C ##1 1'b1
    |-> result_o.cacheable == $past(cache_on_i))
    else $error("fixed cached region caching wrong");
endmodule // mmu_translate

// file: test/core_model.sv
// Core-side model that offers accesses and buffer loads to the unit
module core_model
  import mmu_pkg::*;
(
  input wire logic ref_clk_i,
  output logic acc_valid_o,
  output cpu_access_s access_o,
  output logic tlb_load_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle until the first offer
  initial
  begin
    acc_valid_o = 1'b0;
    access_o = '0;
    tlb_load_o = 1'b0;
  end

  // One access: held for exactly one rising edge, then released
  task automatic offer(input logic [31:0] va, input logic wr, input logic pv,
                       input logic [31:0] wd);
    @(negedge ref_clk_i);
    acc_valid_o = 1'b1;
    access_o = '{vaddr: va, write: wr, priv: pv, wdata: wd};
    @(negedge ref_clk_i);
    acc_valid_o = 1'b0;
    // Released bus shows the inverse, so a stale value never looks valid
    access_o = ~access_o;
  endtask

  // One buffer load: tlb_load held for exactly one rising edge
  task automatic load_entry();
    @(negedge ref_clk_i);
    tlb_load_o = 1'b1;
    @(negedge ref_clk_i);
    tlb_load_o = 1'b0;
  endtask
endmodule // core_model

// file: test/testbench.sv
// Self-checking bench for the translation unit
module testbench;
  import mmu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk_i = 1'b0; // 10 MHz clock
  logic sys_rst_i = 1'b1; // Synchronous reset
  logic acc_valid;
  cpu_access_s acc;
  logic tlb_load;
  logic cache_on = 1'b0; // Cache control levels
  logic wt_sel = 1'b0;
  logic cb_sel = 1'b0;
  logic dsp_on = 1'b0;
  logic resp_valid;
  xlat_res_s res;
  logic [31:0] cache_addr;
  logic [31:0] rdata;
  logic [7:0] flg; // resp, C, WT, ctrl, xy, miss, prot, addr_err
  int err_count = 0;
  int checks_done = 0;
  // Table base as seen in control space; only its low byte is decoded
  localparam logic [31:0] TB_ADDR = {24'hffffff, OFF_TABLE_BASE[7:0]};

  assign flg = {resp_valid, res.cacheable, res.writethrough, res.ctrl_space,
                res.xy_space, res.miss, res.prot, res.addr_err};

  // Clock
  always #50 ref_clk_i = ~ref_clk_i;

  mmu_translate i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .acc_valid_i(acc_valid), .access_i(acc), .tlb_load_i(tlb_load),
    .cache_on_i(cache_on), .mapped_writethrough_sel_i(wt_sel),
    .fixed_copyback_sel_i(cb_sel), .dsp_extension_on_i(dsp_on),
    .resp_valid_o(resp_valid), .result_o(res), .cache_addr_o(cache_addr),
    .rdata_o(rdata));

  core_model i_core (.ref_clk_i(ref_clk_i), .acc_valid_o(acc_valid),
    .access_o(acc), .tlb_load_o(tlb_load));

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Privileged register write and read
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_core.offer(a, 1'b1, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a);
    i_core.offer(a, 1'b0, 1'b1, 32'h0);
  endtask

  // Stage one entry and load it into the next way
  task automatic put(input logic [31:0] hi, input logic [31:0] lo);
    wr(OFF_PTE_HIGH, hi);
    wr(OFF_PTE_LOW, lo);
    i_core.load_entry();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Control bits clear after reset; single select is left free
  task automatic t_reset();
    rd(OFF_XLAT_CTRL);
    chk("ctrl", 32'h0, rdata & 32'hfffffeff);
    $display("t_reset done");
  endtask

  // Aliases fold onto one 29-bit address with translation off
  task automatic t_pass();
    logic [31:0] va[4] = '{32'h00001000, 32'h80001000, 32'ha0001000, 32'hc0001000};
    foreach (va[i])
    begin
      rd(va[i]);
      chk("paddr", 32'h00001000, {3'h0, res.paddr});
      chk("cache_addr", 32'h00001000, cache_addr);
    end
    $display("t_pass done");
  endtask

  // Fixed regions decode without the buffer
  task automatic t_fixed();
    cache_on = 1'b1;
    cb_sel = 1'b1;
    rd(32'h9ffffffc);
    chk("paddr", 32'h1ffffffc, {3'h0, res.paddr});
    chk("flags", 32'hc0, {24'h0, flg});
    chk("cache_addr", 32'h1ffffffc, cache_addr);
    cb_sel = 1'b0;
    rd(32'h80000000);
    chk("flags", 32'he0, {24'h0, flg});
    rd(32'ha0000010);
    chk("paddr", 32'h00000010, {3'h0, res.paddr});
    chk("flags", 32'h80, {24'h0, flg});
    rd(TB_ADDR);
    chk("flags", 32'h90, {24'h0, flg});
    $display("t_fixed done");
  endtask

  // DSP window only while the extension is on
  task automatic t_dsp();
    dsp_on = 1'b1;
    i_core.offer(32'ha5000100, 1'b0, 1'b0, 32'h0);
    chk("flags", 32'h88, {24'h0, flg});
    dsp_on = 1'b0;
    i_core.offer(32'ha5000100, 1'b0, 1'b0, 32'h0);
    chk("flags", 32'h81, {24'h0, flg});
    $display("t_dsp done");
  endtask

  // Registers read back, user access refused and ignored
  task automatic t_regs();
    wr(TB_ADDR, 32'h12345678);
    i_core.offer(TB_ADDR, 1'b1, 1'b0, 32'hffffffff);
    chk("flags", 32'h81, {24'h0, flg});
    rd(TB_ADDR);
    chk("table_base", 32'h12345678, rdata);
    $display("t_regs done");
  endtask

  // Empty buffer misses and records the fault
  task automatic t_miss();
    wr(OFF_XLAT_CTRL, 32'h00000005);
    rd(OFF_XLAT_CTRL);
    chk("ctrl", 32'h1, rdata & 32'h5);
    rd(32'h00403abc);
    chk("flags", 32'h84, {24'h0, flg});
    rd(OFF_FAULT_ADDR);
    chk("fault_address", 32'h00403abc, rdata);
    rd(OFF_PTE_HIGH);
    chk("page_entry_high", 32'h00403800, rdata & 32'hfffffc00);
    $display("t_miss done");
  endtask

  // Hits on 4K and 1K pages and on four ways of one set
  task automatic t_hit();
    wt_sel = 1'b1;
    put(32'h00403012, 32'h01234178);
    rd(32'h00403abc);
    chk("paddr", 32'h01234abc, {3'h0, res.paddr});
    chk("flags", 32'he0, {24'h0, flg});
    chk("cache_addr", 32'h01234abc, cache_addr);
    put(32'h00405412, 32'h00abc560);
    rd(32'h00405523);
    chk("paddr", 32'h00abc523, {3'h0, res.paddr});
    chk("flags", 32'ha0, {24'h0, flg});
    rd(32'h00405123);
    chk("flags", 32'ha4, {24'h0, flg});
    for (int i = 0; i < 4; i++)
      put(32'h00009012 | (i << 18), 32'h00100170 | (i << 12));
    for (int i = 0; i < 4; i++)
    begin
      rd(32'h0000900c | (i << 18));
      chk("paddr", 32'h0010000c | (i << 12), {3'h0, res.paddr});
    end
    $display("t_hit done");
  endtask

  // Process tag selects entries; single mode protects instead
  task automatic t_tag();
    wr(OFF_PTE_HIGH, 32'h00403034);
    rd(32'h00403abc);
    chk("flags", 32'ha4, {24'h0, flg});
    wr(OFF_PTE_HIGH, 32'h00403012);
    rd(32'h00403abc);
    chk("flags", 32'he0, {24'h0, flg});
    wr(OFF_XLAT_CTRL, 32'h00000101);
    wr(OFF_PTE_HIGH, 32'h00403034);
    i_core.offer(32'h00403abc, 1'b0, 1'b0, 32'h0);
    chk("flags", 32'ha2, {24'h0, flg});
    rd(32'h00403abc);
    chk("flags", 32'he0, {24'h0, flg});
    wr(OFF_XLAT_CTRL, 32'h00000001);
    $display("t_tag done");
  endtask

  // Page rights: privileged read only
  task automatic t_prot();
    put(32'h00407012, 32'h00200110);
    rd(32'h00407004);
    chk("paddr", 32'h00200004, {3'h0, res.paddr});
    i_core.offer(32'h00407004, 1'b0, 1'b0, 32'h0);
    chk("flags", 32'ha2, {24'h0, flg});
    wr(32'h00407004, 32'h0);
    chk("flags", 32'ha2, {24'h0, flg});
    $display("t_prot done");
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_pass();
    t_fixed();
    t_dsp();
    t_regs();
    t_miss();
    t_hit();
    t_tag();
    t_prot();
    close_out();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    close_out();
  end
endmodule // testbench
